// ==== logic/dpmc_mode_ctrl.sv ====
// pll mode-control word two with its axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
module dpmc_mode_ctrl
  import dpmc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pll state and controls
  input  wire logic        pll_in_holdover,
  output logic             holdover_mem_reset,
  output logic             force_freerun,
  output logic             tie_correction_reset,
  // failure detection
  input  wire logic        monitor_pri_fail,
  input  wire logic        monitor_sec_fail,
  input  wire logic        primary_loss_in,
  input  wire logic        secondary_loss_in,
  output logic             pri_ref_failed,
  output logic             sec_ref_failed,
  output logic             force_pri_ref,
  output logic             force_sec_ref,
  // clock fail pins
  input  wire logic        a_fail_level,
  input  wire logic        b_fail_level,
  output logic             a_fail_out,
  output logic             a_fail_out_oe,
  output logic             b_fail_out,
  output logic             b_fail_out_oe,
  // backplane references
  input  wire logic        bus_ref_in_one,
  input  wire logic        bus_ref_in_two,
  output logic             bus_ref_one_pll,
  output logic             bus_ref_two_pll,
  // network reference
  input  wire logic [3:0]  local_ref_in,
  output logic             net_ref_out,
  output logic             net_ref_out_oe
);
  // register bus state
  logic        aw_hold_q, aw_hold_d;    // write address captured
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_hold_q,  w_hold_d;     // write data captured
  logic [31:0] w_data_q,  w_data_d;
  logic [3:0]  w_strb_q,  w_strb_d;
  logic        awready_q, awready_d;
  logic        wready_q,  wready_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        arready_q, arready_d;
  logic        rvalid_q,  rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  // software-visible words
  logic [15:0] mode_two_q, mode_two_d;  // pll_mode_word_two
  logic [15:0] mode_one_q, mode_one_d;  // net_ref_out_en lives here
  logic        restart_q,  restart_d;   // divider restart strobe
  // combinational helpers
  logic        aw_take;                 // address handshake this edge
  logic        w_take;                  // data handshake this edge
  logic        wr_fire;                 // both halves present
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [15:0] wr_word;                 // byte-lane merged value
  logic [15:0] status;                  // live block state

  // merge byte lanes into a 16-bit word
  function automatic logic [15:0] dpmc_merge(input logic [15:0] old_w,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb,
                                              input logic [15:0] mask);
    logic [15:0] m;
    m = old_w;
    if (strb[0]) m[7:0]  = data[7:0];
    if (strb[1]) m[15:8] = data[15:8];
    return m & mask;
  endfunction

  // true when an address hits a register
  function automatic logic dpmc_mapped(input logic [7:0] a);
    return (a == ADDR_MODE_TWO) || (a == ADDR_MODE_ONE) || (a == ADDR_STATUS);
  endfunction

  // write channel and register file next state
  always_comb begin
    aw_take   = s_axi_awvalid & awready_q;
    w_take    = s_axi_wvalid & wready_q;
    wr_addr   = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    wr_data   = w_hold_q ? w_data_q : s_axi_wdata;
    wr_strb   = w_hold_q ? w_strb_q : s_axi_wstrb;
    wr_fire   = (aw_hold_q | aw_take) & (w_hold_q | w_take);
    aw_hold_d = aw_hold_q | aw_take;
    aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
    w_hold_d  = w_hold_q | w_take;
    w_data_d  = w_take ? s_axi_wdata : w_data_q;
    w_strb_d  = w_take ? s_axi_wstrb : w_strb_q;
    bvalid_d  = bvalid_q & ~s_axi_bready;
    bresp_d   = bresp_q;
    mode_two_d = mode_two_q;
    mode_one_d = mode_one_q;
    restart_d  = 1'b0;
    wr_word    = 16'h0000;
    if (wr_fire) begin  // both halves in: commit and answer
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = dpmc_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_addr == ADDR_MODE_TWO) begin
        // reserved bits are dropped; software should send zero there
        wr_word    = dpmc_merge(mode_two_q, wr_data, wr_strb, MODE_TWO_MASK);
        mode_two_d = wr_word;
        restart_d  = wr_strb[0];  // divider and source sit in low byte
      end else if (wr_addr == ADDR_MODE_ONE) begin
        mode_one_d = dpmc_merge(mode_one_q, wr_data, wr_strb, MODE_ONE_MASK);
      end
    end
    // ready only for a half not yet held and no answer pending
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d  = ~w_hold_d & ~bvalid_d;
  end

  // register write channel and words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_q  <= 1'b0;
      aw_addr_q  <= 8'h00;
      w_hold_q   <= 1'b0;
      w_data_q   <= 32'h00000000;
      w_strb_q   <= 4'h0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      mode_two_q <= MODE_TWO_RST;
      mode_one_q <= MODE_ONE_RST;
      restart_q  <= 1'b0;
    end else begin
      aw_hold_q  <= aw_hold_d;
      aw_addr_q  <= aw_addr_d;
      w_hold_q   <= w_hold_d;
      w_data_q   <= w_data_d;
      w_strb_q   <= w_strb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      mode_two_q <= mode_two_d;
      mode_one_q <= mode_one_d;
      restart_q  <= restart_d;
    end
  end

  // read channel next state
  always_comb begin
    status = 16'h0000;
    status[ST_HOLDOVER] = pll_in_holdover;
    status[ST_FREERUN]  = force_freerun;
    status[ST_PRI_FAIL] = pri_ref_failed;
    status[ST_SEC_FAIL] = sec_ref_failed;
    status[ST_NET_OUT]  = net_ref_out;
    rvalid_d  = rvalid_q & ~s_axi_rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid & arready_q) begin  // one read in flight at most
      rvalid_d = 1'b1;
      rresp_d  = dpmc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_MODE_TWO: rdata_d = {16'h0000, mode_two_q};
        ADDR_MODE_ONE: rdata_d = {16'h0000, mode_one_q};
        ADDR_STATUS:   rdata_d = {16'h0000, status};
        default:       rdata_d = 32'h00000000;  // unmapped reads zero
      endcase
    end
    arready_d = ~rvalid_d;
  end

  // register read channel
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // pll-side control flops
  logic       hold_rst_q, hold_rst_d;
  logic       freerun_q,  freerun_d;
  logic       tie_rst_q,  tie_rst_d;
  logic       pri_f_q,    pri_f_d;
  logic       sec_f_q,    sec_f_d;
  logic       f_pri_q,    f_pri_d;
  logic       f_sec_q,    f_sec_d;
  logic [3:0] fail_pin_q, fail_pin_d;   // a out, a oe, b out, b oe
  logic [1:0] bus_ref_q,  bus_ref_d;
  logic       net_oe_q,   net_oe_d;
  logic [1:0] fd_mode;

  // control decode from the stored words and the live pll-side inputs
  always_comb begin
    fd_mode    = mode_two_q[FAIL_SEL_LSB +: 2];
    hold_rst_d = mode_two_q[HOLD_RST_BIT];
    // a pulse or level while in holdover drops the loop to freerun
    freerun_d  = mode_two_q[HOLD_RST_BIT] & pll_in_holdover;
    // slave timing needs this held high by software
    tie_rst_d  = mode_two_q[TIE_RST_BIT];
    pri_f_d    = 1'b0;
    sec_f_d    = 1'b0;
    f_pri_d    = 1'b0;
    f_sec_d    = 1'b0;
    unique case (fd_mode)
      DPMC_FD_AUTO: begin  // internal monitor
        pri_f_d = monitor_pri_fail;
        sec_f_d = monitor_sec_fail;
      end
      DPMC_FD_EXT: begin  // external loss pins
        pri_f_d = primary_loss_in;
        sec_f_d = secondary_loss_in;
      end
      DPMC_FD_F_PRI: f_pri_d = 1'b1;
      DPMC_FD_F_SEC: f_sec_d = 1'b1;
    endcase
    fail_pin_d = {a_fail_level, mode_two_q[A_FAIL_EN_BIT],
                  b_fail_level, mode_two_q[B_FAIL_EN_BIT]};
    bus_ref_d  = {bus_ref_in_two, bus_ref_in_one}
                 ^ {2{mode_two_q[BUS_INV_BIT]}};
    net_oe_d   = mode_one_q[NET_OE_BIT];
  end

  // register pll-side controls; adds one cycle to every path
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_rst_q <= 1'b0;
      freerun_q  <= 1'b0;
      tie_rst_q  <= 1'b0;
      pri_f_q    <= 1'b0;
      sec_f_q    <= 1'b0;
      f_pri_q    <= 1'b0;
      f_sec_q    <= 1'b0;
      fail_pin_q <= 4'h0;
      bus_ref_q  <= 2'h0;
      net_oe_q   <= 1'b0;
    end else begin
      hold_rst_q <= hold_rst_d;
      freerun_q  <= freerun_d;
      tie_rst_q  <= tie_rst_d;
      pri_f_q    <= pri_f_d;
      sec_f_q    <= sec_f_d;
      f_pri_q    <= f_pri_d;
      f_sec_q    <= f_sec_d;
      fail_pin_q <= fail_pin_d;
      bus_ref_q  <= bus_ref_d;
      net_oe_q   <= net_oe_d;
    end
  end

  // network reference: pick a local input, then divide
  dpmc_net_ref_div u_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .div_mode (mode_two_q[NET_DIV_LSB +: 2]),
    .restart  (restart_q),
    .ref_in   (local_ref_in[mode_two_q[NET_SRC_LSB +: 2]]),
    .ref_out  (net_ref_out)
  );

  // outputs straight from flops
  assign s_axi_awready        = awready_q;
  assign s_axi_wready         = wready_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = arready_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rdata          = rdata_q;
  assign s_axi_rresp          = rresp_q;
  assign holdover_mem_reset   = hold_rst_q;
  assign force_freerun        = freerun_q;
  assign tie_correction_reset = tie_rst_q;
  assign pri_ref_failed       = pri_f_q;
  assign sec_ref_failed       = sec_f_q;
  assign force_pri_ref        = f_pri_q;
  assign force_sec_ref        = f_sec_q;
  assign a_fail_out           = fail_pin_q[3];
  assign a_fail_out_oe        = fail_pin_q[2];
  assign b_fail_out           = fail_pin_q[1];
  assign b_fail_out_oe        = fail_pin_q[0];
  assign bus_ref_one_pll      = bus_ref_q[0];
  assign bus_ref_two_pll      = bus_ref_q[1];
  assign net_ref_out_oe       = net_oe_q;
endmodule
`default_nettype wire

// ==== logic/dpmc_net_ref_div.sv ====
// divider for the network reference output
`timescale 1ns/1ps
`default_nettype none
module dpmc_net_ref_div
  import dpmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic [1:0] div_mode,
  input  wire logic       restart,
  // reference in, divided out
  input  wire logic       ref_in,
  output logic            ref_out
);
  logic       ref_q;    // previous reference level
  logic       ref_d;
  logic [8:0] cnt_q;    // edges seen in this period
  logic [8:0] cnt_d;
  logic       out_q;    // output flop
  logic       out_d;
  logic [8:0] ratio;    // edges per output period
  logic       rise;     // rising edge of reference

  // counter and output next state
  always_comb begin
    ratio = (div_mode == DPMC_DIV_193) ? DIV_RATIO_193 : DIV_RATIO_256;
    rise  = ref_in & ~ref_q;
    ref_d = ref_in;
    cnt_d = cnt_q;
    out_d = out_q;
    if (restart) begin  // fresh full period after a change
      cnt_d = 9'h000;
      out_d = 1'b0;
    end else begin
      unique case (div_mode)
        DPMC_DIV_PASS: begin  // straight through
          cnt_d = 9'h000;
          out_d = ref_in;
        end
        DPMC_DIV_193, DPMC_DIV_256: begin  // divide by 193 or 256
          if (rise) begin
            cnt_d = (cnt_q == ratio - 9'h001) ? 9'h000 : cnt_q + 9'h001;
          end
          // high for the first half, odd ratio gives the short half high
          out_d = (cnt_d < {1'b0, ratio[8:1]}) && (ratio != 9'h000);
        end
        DPMC_DIV_RSVD: begin  // reserved code parks the output low
          cnt_d = 9'h000;
          out_d = 1'b0;
        end
      endcase
    end
  end

  // register the divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q <= 1'b0;
      cnt_q <= 9'h000;
      out_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign ref_out = out_q;
endmodule
`default_nettype wire

// ==== logic/dpmc_pkg.sv ====
// constants for the pll mode-control word two block
package dpmc_pkg;
  // bus geometry
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  // register byte addresses
  localparam logic [7:0]  ADDR_MODE_TWO  = 8'h00;  // pll_mode_word_two
  localparam logic [7:0]  ADDR_MODE_ONE  = 8'h04;  // holds net_ref_out_en only
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;  // read-only block state
  // reset values
  localparam logic [15:0] MODE_TWO_RST   = 16'h0000;
  localparam logic [15:0] MODE_ONE_RST   = 16'h0000;
  // bits that hold storage; 15..12 and 2 read as zero
  localparam logic [15:0] MODE_TWO_MASK  = 16'h0FFB;
  localparam logic [15:0] MODE_ONE_MASK  = 16'h8000;
  // field positions in pll_mode_word_two
  localparam int unsigned HOLD_RST_BIT   = 11;
  localparam int unsigned TIE_RST_BIT    = 10;
  localparam int unsigned FAIL_SEL_LSB   = 8;
  localparam int unsigned B_FAIL_EN_BIT  = 7;
  localparam int unsigned A_FAIL_EN_BIT  = 6;
  localparam int unsigned BUS_INV_BIT    = 5;
  localparam int unsigned NET_DIV_LSB    = 3;
  localparam int unsigned NET_SRC_LSB    = 0;
  // field position in the first mode word
  localparam int unsigned NET_OE_BIT     = 15;
  // status bit positions
  localparam int unsigned ST_HOLDOVER    = 0;
  localparam int unsigned ST_FREERUN     = 1;
  localparam int unsigned ST_PRI_FAIL    = 2;
  localparam int unsigned ST_SEC_FAIL    = 3;
  localparam int unsigned ST_NET_OUT     = 4;
  // divider ratios
  localparam logic [8:0]  DIV_RATIO_193  = 9'h0C1;
  localparam logic [8:0]  DIV_RATIO_256  = 9'h100;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // failure detect modes
  typedef enum logic [1:0] {
    DPMC_FD_AUTO  = 2'b00,
    DPMC_FD_EXT   = 2'b01,
    DPMC_FD_F_PRI = 2'b10,
    DPMC_FD_F_SEC = 2'b11
  } dpmc_fail_mode_t;
  // network reference divide modes
  typedef enum logic [1:0] {
    DPMC_DIV_PASS = 2'b00,
    DPMC_DIV_193  = 2'b01,
    DPMC_DIV_256  = 2'b10,
    DPMC_DIV_RSVD = 2'b11
  } dpmc_div_mode_t;
endpackage

// ==== test/dpmc_mode_ctrl_asserts.sv ====
// concurrent checks on the ports of the mode-control block
`timescale 1ns/1ps
`default_nettype none
module dpmc_mode_ctrl_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  // pll controls
  input wire logic        pll_in_holdover,
  input wire logic        holdover_mem_reset,
  input wire logic        force_freerun,
  input wire logic        tie_correction_reset,
  input wire logic        pri_ref_failed,
  input wire logic        sec_ref_failed,
  input wire logic        force_pri_ref,
  input wire logic        force_sec_ref,
  // fail pin and references
  input wire logic        a_fail_level,
  input wire logic        a_fail_out,
  input wire logic        a_fail_out_oe,
  input wire logic        bus_ref_in_one,
  input wire logic        bus_ref_in_two,
  input wire logic        bus_ref_one_pll,
  input wire logic        bus_ref_two_pll,
  input wire logic        net_ref_out
);
  logic        live_q;  // low on the first edge after reset, $past is stale there
  logic [7:0]  aa_q;    // last accepted write address
  logic [31:0] wd_q;    // last accepted write data
  logic [3:0]  ws_q;    // last accepted strobes
  logic        ok_two;  // last write went to word two and was accepted
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // capture the write so the response edge can be tied to the data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_q <= 1'h0;
      aa_q   <= 8'h00;
      wd_q   <= 32'h0;
      ws_q   <= 4'h0;
    end else begin
      live_q <= 1'h1;
      if (s_axi_awvalid && s_axi_awready) aa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end
  assign ok_two = (aa_q == dpmc_pkg::ADDR_MODE_TWO) && (s_axi_bresp == dpmc_pkg::RESP_OKAY);
  a_freerun_gate: assert property (live_q |-> force_freerun ==
    (holdover_mem_reset && $past(pll_in_holdover))) else $error("freerun gating wrong");
  a_bus_inv_pair: assert property (live_q |-> (bus_ref_one_pll ^ $past(bus_ref_in_one)) ==
    (bus_ref_two_pll ^ $past(bus_ref_in_two))) else $error("backplane invert differs");
  a_afail_follow: assert property (live_q && a_fail_out_oe && !force_pri_ref &&
    !force_sec_ref |-> a_fail_out == $past(a_fail_level)) else $error("a fail pin wrong");
  a_forced_modes: assert property (force_pri_ref || force_sec_ref |->
    !pri_ref_failed && !sec_ref_failed && (force_pri_ref != force_sec_ref))
    else $error("forced mode outputs wrong");
  a_ctrl_update: assert property ($rose(s_axi_bvalid) && ok_two && ws_q[1] |=>
    holdover_mem_reset == wd_q[11] && tie_correction_reset == wd_q[10])
    else $error("reset controls did not follow write");
  a_afail_enable: assert property ($rose(s_axi_bvalid) && ok_two && ws_q[0] |=>
    a_fail_out_oe == wd_q[6]) else $error("a fail enable did not follow write");
  a_restart_low: assert property ($rose(s_axi_bvalid) && ok_two && ws_q[0] &&
    wd_q[4:3] != 2'h0 |-> ##[1:3] !net_ref_out) else $error("divider did not restart");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  c_freerun: cover property (force_freerun);
  c_forced_sec: cover property (force_sec_ref);
  c_net_rise: cover property ($rose(net_ref_out));
endmodule
bind dpmc_mode_ctrl dpmc_mode_ctrl_asserts dpmc_mode_ctrl_asserts_inst (.*);
`default_nettype wire

// ==== test/dpmc_ref_src.sv ====
// behavioural model of the four local reference clock sources
`timescale 1ns/1ps
`default_nettype none
module dpmc_ref_src (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // local references, source i has a half period of i+1 cycles
  output logic      [3:0] ref_out
);
  logic [1:0] cnt_q [4];  // half-period counters
  // free-running sources; distinct periods make a wrong source select visible
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q   <= '{default: 2'h0};
      ref_out <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cnt_q[i] == 2'(i)) begin
          cnt_q[i]   <= 2'h0;
          ref_out[i] <= ~ref_out[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// register-driven bench for the mode-control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dpmc_pkg::*;
  // bus and pll-side signals, named as the design ports
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, local_ref_in;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, pll_in_holdover, holdover_mem_reset, force_freerun;
  logic        tie_correction_reset, monitor_pri_fail, monitor_sec_fail, primary_loss_in;
  logic        secondary_loss_in, pri_ref_failed, sec_ref_failed, force_pri_ref;
  logic        force_sec_ref, a_fail_level, b_fail_level, a_fail_out, a_fail_out_oe;
  logic        b_fail_out, b_fail_out_oe, bus_ref_in_one, bus_ref_in_two;
  logic        bus_ref_one_pll, bus_ref_two_pll, net_ref_out, net_ref_out_oe;
  int          err_count, compares;
  dpmc_mode_ctrl dpmc_mode_ctrl_inst (.*);
  dpmc_ref_src dpmc_ref_src_inst (.clk(clk), .sys_rst(sys_rst), .ref_out(local_ref_in));
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // counts, verdict, end of run
  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic timeout();
    chk("handshake_wait", 32'h1, 32'h0);
    results();
  endtask
  // outputs lag one clock; three negedges leave margin
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  // axi write; ready sampled at negedge is the one the next edge uses
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ga, gw, b;
    int   n;
    ga = 1'h0;
    gw = 1'h0;
    b  = 1'h0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (n = 0; n < 40 && !b; n++) begin
      @(negedge clk);
      if (s_axi_awready === 1'h1) ga = 1'h1;
      if (s_axi_wready === 1'h1) gw = 1'h1;
      if (s_axi_bvalid === 1'h1) b = 1'h1;
      if (b) chk("bresp", er, s_axi_bresp);
      @(posedge clk);
      if (ga) s_axi_awvalid <= 1'h0;
      if (gw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    if (!b) timeout();
  endtask
  // axi read with data and response check
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic g, r;
    int   n;
    g = 1'h0;
    r = 1'h0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (n = 0; n < 40 && !r; n++) begin
      @(negedge clk);
      if (s_axi_arready === 1'h1) g = 1'h1;
      if (s_axi_rvalid === 1'h1) r = 1'h1;
      if (r) chk("rdata", e, s_axi_rdata);
      if (r) chk("rresp", er, s_axi_rresp);
      @(posedge clk);
      if (g) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    if (!r) timeout();
  endtask
  // cycles between two rising edges of the network reference output
  task automatic per(input int e);
    int   n, t;
    logic p;
    p = 1'h1;
    t = -1;
    settle();
    for (n = 0; n < 1200; n++) begin
      @(negedge clk);
      if (p === 1'h0 && net_ref_out === 1'h1 && t >= 0) break;
      if (p === 1'h0 && net_ref_out === 1'h1) t = n;
      p = net_ref_out;
    end
    chk("net_ref_period", e, n - t);
    if (n == 1200) timeout();
  endtask
  // main sequence
  initial begin
    sys_rst = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {pll_in_holdover, monitor_pri_fail, monitor_sec_fail, primary_loss_in} = 4'h0;
    {secondary_loss_in, a_fail_level, b_fail_level, bus_ref_in_one, bus_ref_in_two} = 5'h00;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    settle();
    chk("oe_reset", 32'h0, {a_fail_out_oe, b_fail_out_oe, net_ref_out_oe});
    rd(ADDR_MODE_TWO, 32'h0, RESP_OKAY);
    wr(ADDR_MODE_TWO, 16'h0FFF, 4'h3, RESP_OKAY);
    rd(ADDR_MODE_TWO, 32'h0FFB, RESP_OKAY);
    chk("ctrl_high", 32'hF, {holdover_mem_reset, tie_correction_reset, a_fail_out_oe, b_fail_out_oe});
    wr(ADDR_MODE_TWO, 16'h0000, 4'h2, RESP_OKAY);
    rd(ADDR_MODE_TWO, 32'h00FB, RESP_OKAY);
    chk("ctrl_low", 32'h3, {holdover_mem_reset, tie_correction_reset, a_fail_out_oe, b_fail_out_oe});
    // unmapped and read-only places
    wr(8'h0C, 16'hFFFF, 4'h3, RESP_SLVERR);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 16'hFFFF, 4'h3, RESP_OKAY);
    rd(ADDR_MODE_TWO, 32'h00FB, RESP_OKAY);
    // holdover with and without the memory reset bit
    @(posedge clk);
    pll_in_holdover <= 1'h1;
    settle();
    chk("freerun_off", 32'h0, force_freerun);
    wr(ADDR_MODE_TWO, 16'h08FB, 4'h3, RESP_OKAY);
    settle();
    chk("freerun_on", 32'h1, force_freerun);
    rd(ADDR_STATUS, 32'h3, RESP_OKAY);
    @(posedge clk);
    pll_in_holdover <= 1'h0;
    monitor_pri_fail <= 1'h1;
    secondary_loss_in <= 1'h1;
    settle();
    chk("freerun_left", 32'h0, force_freerun);
    // every failure detect code
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE_TWO, {6'h00, 2'(m), 8'h00}, 4'h3, RESP_OKAY);
      settle();
      chk("fail_detect", 4'h8 >> m, {pri_ref_failed, sec_ref_failed, force_pri_ref, force_sec_ref});
    end
    // fail enables and backplane invert, all combinations
    @(posedge clk);
    a_fail_level <= 1'h1;
    b_fail_level <= 1'h1;
    bus_ref_in_one <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_MODE_TWO, {8'h00, 3'(k), 5'h00}, 4'h3, RESP_OKAY);
      settle();
      chk("pins", {k[1], k[2], ~k[0], k[0]}, {a_fail_out_oe, b_fail_out_oe, bus_ref_one_pll, bus_ref_two_pll});
      if (k[1]) chk("a_fail_out", 32'h1, a_fail_out);
      if (k[2]) chk("b_fail_out", 32'h1, b_fail_out);
    end
    // network reference: enable, sources, dividers
    wr(ADDR_MODE_ONE, 16'h8000, 4'h3, RESP_OKAY);
    rd(ADDR_MODE_ONE, 32'h8000, RESP_OKAY);
    chk("net_oe", 32'h1, net_ref_out_oe);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MODE_TWO, {14'h0000, 2'(s)}, 4'h3, RESP_OKAY);
      per(2 * (s + 1));
    end
    wr(ADDR_MODE_TWO, 16'h0008, 4'h3, RESP_OKAY);
    per(386);
    wr(ADDR_MODE_TWO, 16'h0010, 4'h3, RESP_OKAY);
    per(512);
    wr(ADDR_MODE_TWO, 16'h0018, 4'h3, RESP_OKAY);
    repeat (20) @(negedge clk);
    chk("net_rsvd", 32'h0, net_ref_out);
    // reset in mid-run clears the output enable word
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    settle();
    rd(ADDR_MODE_ONE, 32'h0, RESP_OKAY);
    chk("net_oe_reset", 32'h0, net_ref_out_oe);
    chk("ctrl_reset", 32'h0, {holdover_mem_reset, tie_correction_reset});
    results();
  end
endmodule
`default_nettype wire
